// File: bench/dbtc_pulse_src.sv
`timescale 1ns/100ps
// Stands in for the port edge detectors: every event is one clock-synchronous high cycle.
module dbtc_pulse_src (
  input wire logic hclk,
  output logic ext_count_pulse,
  output logic low_capture_pulse,
  output logic high_capture_pulse
);
  // All lines idle low until a scenario asks for events.
  initial
  begin
    ext_count_pulse = 1'b0;
    low_capture_pulse = 1'b0;
    high_capture_pulse = 1'b0;
  end

  // Holds one line high for n cycles, giving n back-to-back events (0 count, 1 low, 2 high).
  task automatic send(input int kind, input int n);
    @(posedge hclk);
    case (kind)
      0: ext_count_pulse <= 1'b1;
      1: low_capture_pulse <= 1'b1;
      default: high_capture_pulse <= 1'b1;
    endcase
    repeat (n) @(posedge hclk);
    {ext_count_pulse, low_capture_pulse, high_capture_pulse} <= 3'b000;
  endtask : send
endmodule : dbtc_pulse_src

// File: bench/dbtc_timer_test.sv
`timescale 1ns/100ps
`include "dbtc_consts.svh"
module dbtc_timer_test;
  localparam logic [15:0] i_ctrl = `DBTC_IDX_TIMER_CONTROL;
  localparam logic [15:0] i_prr = `DBTC_IDX_PRESCALER_MATCH;
  localparam logic [15:0] i_cntl = `DBTC_IDX_COUNT_LOW_BYTE;
  localparam logic [15:0] i_cnth = `DBTC_IDX_COUNT_HIGH_BYTE;
  localparam logic [15:0] i_mdl = `DBTC_IDX_MATCH_DATA_LOW;
  localparam logic [15:0] i_mdh = `DBTC_IDX_MATCH_DATA_HIGH;
  localparam logic [15:0] i_capl = `DBTC_IDX_CAPTURE_LOW;
  localparam logic [15:0] i_caph = `DBTC_IDX_CAPTURE_HIGH;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, high_irq, low_irq;
  logic [31:0] hrdata;
  logic ext_count_pulse, low_capture_pulse, high_capture_pulse;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;

  dbtc_pulse_src src (.hclk(hclk), .ext_count_pulse(ext_count_pulse),
    .low_capture_pulse(low_capture_pulse), .high_capture_pulse(high_capture_pulse));
  dbtc_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_count_pulse(ext_count_pulse),
    .low_capture_pulse(low_capture_pulse), .high_capture_pulse(high_capture_pulse),
    .high_irq(high_irq), .low_irq(low_irq));

  // Clock and a cycle ceiling, so a stuck handshake still reaches the verdict.
  always #12.5 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic summarize;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One single AHB-Lite word transfer; the leading edge leaves an idle cycle between transfers,
  // which keeps a read from sampling the register before a preceding write lands.
  task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {14'h0, idx, 2'b00};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask : bus

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    bus(idx, 1'b1, d, unused);
  endtask : wr

  task automatic rchk(input logic [15:0] idx, input logic [7:0] exp, input string nm);
    logic [7:0] rd;
    bus(idx, 1'b0, 8'h00, rd);
    chk(nm, exp, rd);
  endtask : rchk

  // Reset values, read-write and read-only access, and an unmapped word.
  task automatic t_regs;
    for (int k = 0; k < 8; k++)
    begin
      rchk(i_ctrl + 16'(k), 8'h00, "reset value");
    end
    wr(16'hfe18, 8'hff);
    rchk(16'hfe18, 8'h00, "unmapped");
    chk("hresp", 8'h00, {7'h0, hresp});
    wr(i_cntl, 8'h55);
    rchk(i_cntl, 8'h00, "count_low_byte");
    wr(i_mdh, 8'h5a);
    rchk(i_mdh, 8'h5a, "match_data_high");
  endtask : t_regs

  // External counting in the low byte: period, capture, buffer reload, sticky flag, stop.
  task automatic t_ext;
    wr(i_mdl, 8'h02);
    wr(i_ctrl, 8'h51);
    src.send(0, 2);
    rchk(i_cntl, 8'h02, "count_low_byte");
    src.send(1, 1);
    rchk(i_capl, 8'h02, "capture_low");
    chk("low_irq", 8'h00, {7'h0, low_irq});
    wr(i_mdl, 8'h05);
    // Match at 2 wraps to 0, then two more events: 1, 2.
    src.send(0, 3);
    rchk(i_cntl, 8'h02, "count_low_byte");
    rchk(i_ctrl, 8'h53, "timer_control");
    chk("low_irq", 8'h01, {7'h0, low_irq});
    // With the reloaded buffer of 5 the byte reaches 5; a stale buffer would wrap at 2.
    src.send(0, 3);
    rchk(i_cntl, 8'h05, "count_low_byte");
    chk("high_irq", 8'h00, {7'h0, high_irq});
    wr(i_ctrl, 8'h51);
    // The request is a level of registered bits, so look one edge after the write lands.
    @(posedge hclk);
    chk("low_irq", 8'h00, {7'h0, low_irq});
    wr(i_ctrl, 8'h00);
    rchk(i_cntl, 8'h00, "count_low_byte");
  endtask : t_ext

  // Sixteen-bit external counting: the low byte alone must not match, both flags rise together.
  task automatic t_long;
    wr(i_mdl, 8'h01);
    wr(i_mdh, 8'h01);
    wr(i_ctrl, 8'hf5);
    src.send(0, 257);
    rchk(i_cnth, 8'h01, "count_high_byte");
    rchk(i_ctrl, 8'hf5, "timer_control");
    // In long mode the low-side capture input is not the low capture's source.
    src.send(1, 1);
    rchk(i_capl, 8'h02, "capture_low");
    src.send(2, 1);
    rchk(i_capl, 8'h01, "capture_low");
    rchk(i_caph, 8'h01, "capture_high");
    src.send(0, 1);
    rchk(i_ctrl, 8'hff, "timer_control");
    rchk(i_cntl, 8'h00, "count_low_byte");
    chk("high_irq", 8'h01, {7'h0, high_irq});
    wr(i_ctrl, 8'h00);
    rchk(i_cnth, 8'h00, "count_high_byte");
  endtask : t_long

  // Prescaled counting in modes 0 and 2. The snapshots lie 60 cycles apart, a whole
  // number of prescaler periods for both settings, so the tick phase cannot matter.
  task automatic t_presc;
    logic [7:0] l0, h0, l1, h1;
    wr(i_mdl, 8'hff);
    wr(i_mdh, 8'hff);
    for (int md = 0; md < 2; md++)
    begin
      for (int p = 1; p < 5; p += 3)
      begin
        wr(i_prr, 8'(p));
        wr(i_ctrl, (md == 1) ? 8'he0 : 8'hc0);
        bus(i_cntl, 1'b0, 8'h00, l0);
        bus(i_cnth, 1'b0, 8'h00, h0);
        // Six bus cycles plus this wait put matching snapshots 60 cycles apart.
        repeat (54) @(posedge hclk);
        bus(i_cntl, 1'b0, 8'h00, l1);
        bus(i_cnth, 1'b0, 8'h00, h1);
        chk("low step", 8'(60 / (p + 1)), l1 - l0);
        chk("high step", (md == 0) ? 8'(60 / (p + 1)) : 8'h00, h1 - h0);
        wr(i_ctrl, 8'h00);
      end
    end
  endtask : t_presc

  // Main sequence.
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_ext();
    t_long();
    t_presc();
    summarize();
  end
endmodule : dbtc_timer_test

// File: common/dbtc_consts.svh
`ifndef DBTC_CONSTS_SVH
`define DBTC_CONSTS_SVH

// Register indices; each register sits at byte address four times its index.
`define DBTC_IDX_TIMER_CONTROL 16'hfe10
`define DBTC_IDX_PRESCALER_MATCH 16'hfe11
`define DBTC_IDX_COUNT_LOW_BYTE 16'hfe12
`define DBTC_IDX_COUNT_HIGH_BYTE 16'hfe13
`define DBTC_IDX_MATCH_DATA_LOW 16'hfe14
`define DBTC_IDX_MATCH_DATA_HIGH 16'hfe15
`define DBTC_IDX_CAPTURE_LOW 16'hfe16
`define DBTC_IDX_CAPTURE_HIGH 16'hfe17

// Field positions inside timer_control.
`define DBTC_BIT_HIGH_RUN 7
`define DBTC_BIT_LOW_RUN 6
`define DBTC_BIT_LENGTH_SELECT 5
`define DBTC_BIT_LOW_CLOCK_SELECT 4
`define DBTC_BIT_HIGH_MATCH_FLAG 3
`define DBTC_BIT_HIGH_IRQ_ENABLE 2
`define DBTC_BIT_LOW_MATCH_FLAG 1
`define DBTC_BIT_LOW_IRQ_ENABLE 0

// Reset values.
`define DBTC_RST_BYTE 8'h00

`endif

// File: common/dbtc_pkg.sv
package dbtc_pkg;

  // Register select decoded from the low three index bits.
  typedef enum logic [2:0] {
    DBTC_SEL_CTRL = 3'b000,
    DBTC_SEL_PRR = 3'b001,
    DBTC_SEL_CNTL = 3'b010,
    DBTC_SEL_CNTH = 3'b011,
    DBTC_SEL_MDL = 3'b100,
    DBTC_SEL_MDH = 3'b101,
    DBTC_SEL_CAPL = 3'b110,
    DBTC_SEL_CAPH = 3'b111
  } dbtc_sel_e;

  // Whole state of the timer block.
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] prr;
    logic [7:0] pre_cnt;
    logic [7:0] cnt_l;
    logic [7:0] cnt_h;
    logic [7:0] mdl;
    logic [7:0] mdh;
    logic [7:0] buf_l;
    logic [7:0] buf_h;
    logic [7:0] cap_l;
    logic [7:0] cap_h;
    logic wr_pend;
    dbtc_sel_e wr_sel;
    logic [7:0] rdata;
  } dbtc_state_s;

endpackage : dbtc_pkg

// File: hdl/dbtc_timer.sv
`timescale 1ns/100ps
`include "dbtc_consts.svh"
// Behaviour
// - Stopped low buffer follows low match data.
// - Stopped high buffer follows high match data.
// - Low capture source chosen by length select.
// - High capture latches high byte always.
// - Count clocks chosen by length and source.
// - Stopped high byte holds at zero.
// - Stopped low byte holds at zero.
// - Long mode matches all sixteen bits.
// - Low source: prescaler or external pulse.
// - High flag sticky until software clears.
// - Low flag sticky until software clears.
// - High request while enable and flag.
// - Low request while enable and flag.
// - Long match sets both flags together while the high byte runs.
// - Prescaler register write restarts prescaler.
// - Prescaler pulse every value plus one cycles.
// - Low byte read-only, counts selected pulses.
// - High byte counts prescaler or low carry.
// - Byte returns to zero on stop or match.
// - Prescaler counts from zero, restarts on match.
module dbtc_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_count_pulse,
  input wire logic low_capture_pulse,
  input wire logic high_capture_pulse,
  output logic high_irq,
  output logic low_irq
);

  dbtc_pkg::dbtc_state_s st_r;
  dbtc_pkg::dbtc_state_s st_nxt;
  logic run_l;
  logic run_h;
  logic long_mode;
  logic pre_tick;
  logic inc_l;
  logic inc_h;
  logic match_l;
  logic match_h;
  logic low_cap;
  logic addr_take;
  logic [3:0] dec;
  logic ctrl_wr;
  logic prr_wr;

  // Maps a byte address onto a register select; bit 3 flags a hit.
  function automatic logic [3:0] dbtc_decode(input logic [31:0] a);
    logic [15:0] idx;
    idx = a[17:2];
    if ((a[31:18] == 14'h0000) && (a[1:0] == 2'h0) &&
        (idx >= `DBTC_IDX_TIMER_CONTROL) && (idx <= `DBTC_IDX_CAPTURE_HIGH))
      dbtc_decode = {1'b1, idx[2:0]};
    else
      dbtc_decode = 4'h0;
  endfunction : dbtc_decode

  // Next value of a counter byte: wraps to zero on its match so the period is match plus one.
  function automatic logic [7:0] dbtc_step(input logic [7:0] c, input logic inc,
                                           input logic hit, input logic run);
    if (!run)
      dbtc_step = 8'h00;
    else if (inc && hit)
      dbtc_step = 8'h00;
    else if (inc)
      dbtc_step = c + 8'h01;
    else
      dbtc_step = c;
  endfunction : dbtc_step

  // The slave never stalls and never errors.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h000000, st_r.rdata};

  // Requests are plain levels of the flag and enable pairs.
  assign high_irq = st_r.ctrl[`DBTC_BIT_HIGH_MATCH_FLAG] &
                    st_r.ctrl[`DBTC_BIT_HIGH_IRQ_ENABLE];
  assign low_irq = st_r.ctrl[`DBTC_BIT_LOW_MATCH_FLAG] &
                   st_r.ctrl[`DBTC_BIT_LOW_IRQ_ENABLE];

  // Count enables and match detection, shared by the state update and the checks.
  always_comb
  begin
    run_l = st_r.ctrl[`DBTC_BIT_LOW_RUN];
    run_h = st_r.ctrl[`DBTC_BIT_HIGH_RUN];
    long_mode = st_r.ctrl[`DBTC_BIT_LENGTH_SELECT];
    pre_tick = (st_r.pre_cnt == st_r.prr);
    // External pulses are taken as already synchronous one-cycle events.
    inc_l = run_l & (st_r.ctrl[`DBTC_BIT_LOW_CLOCK_SELECT] ?
                     ext_count_pulse : pre_tick);
    if (long_mode)
    begin
      // The high byte takes the low byte's carry; match needs all sixteen bits.
      inc_h = run_h & inc_l & (st_r.cnt_l == 8'hff);
      match_l = inc_l & ({st_r.cnt_h, st_r.cnt_l} == {st_r.buf_h, st_r.buf_l});
      match_h = match_l;
    end
    else
    begin
      inc_h = run_h & pre_tick;
      match_l = inc_l & (st_r.cnt_l == st_r.buf_l);
      match_h = inc_h & (st_r.cnt_h == st_r.buf_h);
    end
    low_cap = long_mode ? high_capture_pulse : low_capture_pulse;
    addr_take = hsel & htrans[1] & hready;
    dec = dbtc_decode(haddr);
    ctrl_wr = st_r.wr_pend & (st_r.wr_sel == dbtc_pkg::DBTC_SEL_CTRL);
    prr_wr = st_r.wr_pend & (st_r.wr_sel == dbtc_pkg::DBTC_SEL_PRR);
  end

  // Next state of the whole block.
  always_comb
  begin
    st_nxt = st_r;
    // The prescaler always runs; a write to its match register restarts it.
    if (prr_wr || pre_tick)
      st_nxt.pre_cnt = 8'h00;
    else
      st_nxt.pre_cnt = st_r.pre_cnt + 8'h01;
    // In long mode the low carry is only seen when both bytes run alike.
    st_nxt.cnt_l = dbtc_step(st_r.cnt_l, inc_l, match_l, run_l);
    st_nxt.cnt_h = dbtc_step(st_r.cnt_h, inc_h, match_h, run_h);
    if (long_mode && run_h && match_l)
      st_nxt.cnt_h = 8'h00;
    // Buffers track the data registers while stopped and reload on a match while running.
    if (!run_l || match_l)
      st_nxt.buf_l = st_r.mdl;
    if (!run_h || match_h)
      st_nxt.buf_h = st_r.mdh;
    // Captures sample the count as it stood before this edge.
    if (low_cap)
      st_nxt.cap_l = st_r.cnt_l;
    if (high_capture_pulse)
      st_nxt.cap_h = st_r.cnt_h;
    // Bus writes land in the data phase; the counters and captures have no write path.
    if (ctrl_wr)
      st_nxt.ctrl = hwdata[7:0];
    if (prr_wr)
      st_nxt.prr = hwdata[7:0];
    if (st_r.wr_pend && (st_r.wr_sel == dbtc_pkg::DBTC_SEL_MDL))
      st_nxt.mdl = hwdata[7:0];
    if (st_r.wr_pend && (st_r.wr_sel == dbtc_pkg::DBTC_SEL_MDH))
      st_nxt.mdh = hwdata[7:0];
    // A match wins over a clearing write in the same cycle, so no event is lost.
    if (match_h && run_h)
      st_nxt.ctrl[`DBTC_BIT_HIGH_MATCH_FLAG] = 1'b1;
    if (match_l && run_l)
      st_nxt.ctrl[`DBTC_BIT_LOW_MATCH_FLAG] = 1'b1;
    // Address phase: remember writes, and snapshot read data so it comes from a flop.
    st_nxt.wr_pend = addr_take & hwrite & dec[3];
    st_nxt.wr_sel = dbtc_pkg::dbtc_sel_e'(dec[2:0]);
    st_nxt.rdata = 8'h00;
    if (addr_take && !hwrite && dec[3])
    begin
      unique case (dbtc_pkg::dbtc_sel_e'(dec[2:0]))
        dbtc_pkg::DBTC_SEL_CTRL: st_nxt.rdata = st_r.ctrl;
        dbtc_pkg::DBTC_SEL_PRR: st_nxt.rdata = st_r.prr;
        dbtc_pkg::DBTC_SEL_CNTL: st_nxt.rdata = st_r.cnt_l;
        dbtc_pkg::DBTC_SEL_CNTH: st_nxt.rdata = st_r.cnt_h;
        dbtc_pkg::DBTC_SEL_MDL: st_nxt.rdata = st_r.mdl;
        dbtc_pkg::DBTC_SEL_MDH: st_nxt.rdata = st_r.mdh;
        dbtc_pkg::DBTC_SEL_CAPL: st_nxt.rdata = st_r.cap_l;
        dbtc_pkg::DBTC_SEL_CAPH: st_nxt.rdata = st_r.cap_h;
      endcase
    end
  end

  // State register; everything clears to zero, captures included.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r.ctrl <= `DBTC_RST_BYTE;
      st_r.prr <= `DBTC_RST_BYTE;
      st_r.pre_cnt <= `DBTC_RST_BYTE;
      st_r.cnt_l <= `DBTC_RST_BYTE;
      st_r.cnt_h <= `DBTC_RST_BYTE;
      st_r.mdl <= `DBTC_RST_BYTE;
      st_r.mdh <= `DBTC_RST_BYTE;
      st_r.buf_l <= `DBTC_RST_BYTE;
      st_r.buf_h <= `DBTC_RST_BYTE;
      st_r.cap_l <= `DBTC_RST_BYTE;
      st_r.cap_h <= `DBTC_RST_BYTE;
      st_r.wr_pend <= 1'b0;
      st_r.wr_sel <= dbtc_pkg::DBTC_SEL_CTRL;
      st_r.rdata <= `DBTC_RST_BYTE;
    end
    else
      st_r <= st_nxt;
  end

  default clocking dbtc_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Buffers follow the data registers while stopped.
  low_buf_follow_a: assert property (!run_l |=> st_r.buf_l == $past(st_r.mdl))
    else $error("low buffer not following match data while stopped");
  high_buf_follow_a: assert property (!run_h |=> st_r.buf_h == $past(st_r.mdh))
    else $error("high buffer not following match data while stopped");

  // While running, a buffer only moves on its own match, so rewriting the data
  // register cannot shorten the period that is already under way.
  low_buf_hold_a: assert property (
    run_l && !match_l |=> st_r.buf_l == $past(st_r.buf_l))
    else $error("low buffer moved without a match");
  low_buf_reload_a: assert property (
    run_l && match_l |=> st_r.buf_l == $past(st_r.mdl))
    else $error("low buffer not reloaded on match");
  high_buf_hold_a: assert property (
    run_h && !match_h |=> st_r.buf_h == $past(st_r.buf_h))
    else $error("high buffer moved without a match");
  high_buf_reload_a: assert property (
    run_h && match_h |=> st_r.buf_h == $past(st_r.mdh))
    else $error("high buffer not reloaded on match");

  // Captures take the count of the pulse cycle and otherwise hold.
  low_capture_a: assert property (
    long_mode && high_capture_pulse |=> st_r.cap_l == $past(st_r.cnt_l))
    else $error("low capture missed in long mode");
  low_capture_short_a: assert property (
    !long_mode && low_capture_pulse |=> st_r.cap_l == $past(st_r.cnt_l))
    else $error("low capture missed in byte mode");
  low_capture_hold_a: assert property (
    !(long_mode ? high_capture_pulse : low_capture_pulse) |=> $stable(st_r.cap_l))
    else $error("low capture changed without its pulse");
  high_capture_a: assert property (
    high_capture_pulse |=> st_r.cap_h == $past(st_r.cnt_h))
    else $error("high capture missed");
  high_capture_hold_a: assert property (
    !high_capture_pulse |=> $stable(st_r.cap_h))
    else $error("high capture changed without its pulse");

  // Stopped bytes sit at zero.
  high_stop_zero_a: assert property (!run_h |=> st_r.cnt_h == 8'h00)
    else $error("high byte not zero while stopped");
  low_stop_zero_a: assert property (!run_l |=> st_r.cnt_l == 8'h00)
    else $error("low byte not zero while stopped");

  // Count clock selection: each byte moves only on the source its mode picks.
  // A wrong source would still count, just at the wrong rate, so both sides are checked.
  low_ext_step_a: assert property (
    run_l && st_r.ctrl[4] && ext_count_pulse && st_r.cnt_l != st_r.buf_l
    |=> st_r.cnt_l == $past(st_r.cnt_l) + 8'h01)
    else $error("low byte missed an external pulse");
  low_ext_only_a: assert property (
    run_l && st_r.ctrl[4] && !ext_count_pulse |=> $stable(st_r.cnt_l))
    else $error("low byte moved without an external pulse");
  low_pre_only_a: assert property (
    run_l && !st_r.ctrl[4] && !pre_tick |=> $stable(st_r.cnt_l))
    else $error("low byte moved without a prescaler pulse");
  short_high_step_a: assert property (
    !long_mode && run_h && pre_tick && st_r.cnt_h != st_r.buf_h
    |=> st_r.cnt_h == $past(st_r.cnt_h) + 8'h01)
    else $error("high byte missed a prescaler pulse");
  long_high_quiet_a: assert property (
    long_mode && run_h && !inc_l |=> $stable(st_r.cnt_h))
    else $error("high byte moved without a low carry");

  // A running byte steps by one on a non-matching count event.
  low_count_step_a: assert property (
    inc_l && !match_l |=> st_r.cnt_l == $past(st_r.cnt_l) + 8'h01)
    else $error("low byte did not increment");
  long_carry_a: assert property (
    long_mode && run_h && inc_l && st_r.cnt_l == 8'hff && !match_l
    |=> st_r.cnt_h == $past(st_r.cnt_h) + 8'h01 && st_r.cnt_l == 8'h00)
    else $error("carry into high byte lost");
  long_no_carry_a: assert property (
    long_mode && run_h && inc_l && st_r.cnt_l != 8'hff && !match_l
    |=> $stable(st_r.cnt_h))
    else $error("high byte moved without a carry");

  // Byte mode matches one byte; long mode needs all sixteen bits, so a low byte that
  // equals its buffer on its own must neither wrap nor flag.
  short_low_match_a: assert property (
    !long_mode && inc_l && st_r.cnt_l == st_r.buf_l |=> st_r.cnt_l == 8'h00 && st_r.ctrl[1])
    else $error("byte-mode low match did not wrap and flag");
  long_low_only_a: assert property (
    long_mode && inc_l && st_r.cnt_h != st_r.buf_h && !st_r.ctrl[1] && !ctrl_wr
    |=> !st_r.ctrl[1])
    else $error("low flag set by a low byte match alone in long mode");
  long_match_a: assert property (
    long_mode && match_l && run_h
    |=> st_r.cnt_l == 8'h00 && st_r.cnt_h == 8'h00 && st_r.ctrl[3] && st_r.ctrl[1])
    else $error("sixteen-bit match did not clear and flag both bytes");

  // Flags hold until a control write, rise only on a match, and a match beats a
  // clearing write in the same cycle so that no event is lost.
  high_flag_sticky_a: assert property (st_r.ctrl[3] && !ctrl_wr |=> st_r.ctrl[3])
    else $error("high match flag dropped without a write");
  high_flag_set_a: assert property (
    match_h && run_h |=> st_r.ctrl[3])
    else $error("high match flag not set on match");
  high_flag_quiet_a: assert property (
    !st_r.ctrl[3] && !match_h && !ctrl_wr |=> !st_r.ctrl[3])
    else $error("high match flag set without a match");
  low_flag_set_a: assert property (match_l ##1 1'b1 |-> st_r.ctrl[1])
    else $error("low match flag not set on match");
  low_flag_sticky_a: assert property (
    st_r.ctrl[1] && !ctrl_wr |=> st_r.ctrl[1])
    else $error("low match flag dropped without a write");
  low_flag_quiet_a: assert property (
    !st_r.ctrl[1] && !match_l && !ctrl_wr |=> !st_r.ctrl[1])
    else $error("low match flag set without a match");
  low_set_wins_a: assert property (
    match_l && ctrl_wr |=> st_r.ctrl[1])
    else $error("clearing write beat a low match");

  // Requests follow a match when enabled, and stay quiet without a flag.
  low_irq_rise_a: assert property (
    match_l && st_r.ctrl[0] && !ctrl_wr |=> low_irq)
    else $error("low request missing after match");
  high_irq_rise_a: assert property (
    match_h && st_r.ctrl[2] && !ctrl_wr |=> high_irq)
    else $error("high request missing after match");
  low_irq_off_a: assert property (!st_r.ctrl[1] |-> !low_irq)
    else $error("low request without its flag");
  high_irq_off_a: assert property (!st_r.ctrl[3] |-> !high_irq)
    else $error("high request without its flag");

  // Prescaler restarts on a write or on its own match and never runs past its
  // register, so a smaller value written mid-count cannot cause a long wrap.
  pre_restart_a: assert property (prr_wr || pre_tick |=> st_r.pre_cnt == 8'h00)
    else $error("prescaler did not restart");
  pre_period_a: assert property (
    st_r.prr == 8'h01 && pre_tick && !prr_wr ##1 !prr_wr |=> pre_tick)
    else $error("prescaler period wrong");
  pre_step_a: assert property (
    !prr_wr && !pre_tick |=> st_r.pre_cnt == $past(st_r.pre_cnt) + 8'h01)
    else $error("prescaler did not step");
  pre_bound_a: assert property (st_r.pre_cnt <= st_r.prr)
    else $error("prescaler ran past its match value");

  // The slave answers at once with OKAY; read data is zero outside a read data phase
  // so that a stale byte never shows on the shared read bus.
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or errored");
  rdata_idle_a: assert property (
    !(addr_take && !hwrite) |=> hrdata == 32'h00000000)
    else $error("read data not cleared outside a read");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h000000)
    else $error("upper read data bits not zero");

  // Writes land at the end of their data phase; counters have no write path.
  prr_write_a: assert property (
    prr_wr |=> st_r.prr == $past(hwdata[7:0]) && st_r.pre_cnt == 8'h00)
    else $error("prescaler match write lost");
  ctrl_write_a: assert property (
    ctrl_wr && !match_l && !match_h
    |=> st_r.ctrl == $past(hwdata[7:0]))
    else $error("control write lost");
  low_data_write_a: assert property (
    st_r.wr_pend && st_r.wr_sel == dbtc_pkg::DBTC_SEL_MDL |=> st_r.mdl == $past(hwdata[7:0]))
    else $error("low match data write lost");
  high_data_write_a: assert property (
    st_r.wr_pend && st_r.wr_sel == dbtc_pkg::DBTC_SEL_MDH |=> st_r.mdh == $past(hwdata[7:0]))
    else $error("high match data write lost");
  count_read_only_a: assert property (
    st_r.wr_pend && st_r.wr_sel == dbtc_pkg::DBTC_SEL_CNTL && run_l && !inc_l
    |=> $stable(st_r.cnt_l))
    else $error("low count byte took a bus write");

endmodule : dbtc_timer
